// [gamma_power_mode_control.sv]
// Operating mode, 8-colour gating and gamma register decode, AHB-Lite slave.
// Assumes bus, polarity and pixel inputs come from logic on REF_CLK.
//
// Behaviour
// - Normal, idle off, awake: whole panel, full colour range
// - Partial, idle off, awake: selected area only, full colour range
// - Normal, idle on, awake: whole panel limited to eight colours
// - Partial, idle on, awake: selected area, eight colours only
// - Sleep stops booster, oscillator, panel drive; bus and memory survive
// - Modes change only by command; power off never by command
// - Eight-colour mode uses only end grayscales, cuts middle supplies
// - Eight-colour mode ignores fine adjust, shows component MSB only
// - Thirty-two grayscales, fifteen reference levels per polarity
// - Separate positive and negative sets, chosen by driven polarity
// - Two seven-bit centre fields per polarity pick selector taps
// - Centre field n decodes to 2n resistor units
// - Offsets 0-2: 2n up to 31, then 66 plus 4 per step
// - Offsets 3-5: 4n up to 32, then 128 plus 2 per step
// - Six six-bit offset fields per polarity set amplitude
// - Seven five-bit fine fields drive 32-to-1 selectors
// - Fine selectors held off while eight-colour mode selected
//
// The address map and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ns
`include "gpm_defs.svh"

module gamma_power_mode_control (
   // Clock and reset
   input  wire logic              REF_CLK,
   input  wire logic              RST_B,
   // AHB-Lite slave
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output      logic              HREADYOUT,
   output      logic              HRESP,
   output      logic [31:0]       HRDATA,
   // Panel timing and pixel stream
   input  wire logic              POLARITY_NEG,
   input  wire gpm_pkg::pixel_t   PIXEL_IN,
   // Analogue and driver controls
   output      gpm_pkg::gamma_tap_t GAMMA_TAP,
   output      gpm_pkg::power_ctl_t POWER_CTL,
   output      gpm_pkg::pixel_t   PIXEL_OUT
);
   import gpm_pkg::*;

   logic [6:0]  gam      [`GAMMA_FIELDS];
   logic [6:0]  next_gam [`GAMMA_FIELDS];
   op_mode_t    mode;
   op_mode_t    next_mode;
   logic        wr_pend;
   logic        next_wr_pend;
   logic [11:0] wr_addr;
   logic [11:0] next_wr_addr;
   logic [31:0] next_rdata;
   gamma_tap_t  next_tap;
   power_ctl_t  next_pwr;
   pixel_t      next_pix;
   logic        addr_ok;
   logic        color8;

   // Word-aligned hit on a gamma field
   function automatic logic is_gamma(input logic [31:0] a);
      is_gamma = (a[31:12] == 20'h0_0000) && (a[1:0] == 2'b00) &&
                 (a[11:0] >= `ADDR_GAMMA_BASE) &&
                 (a[11:0] <= `ADDR_GAMMA_LAST);
   endfunction

   function automatic logic [4:0] gam_index(input logic [31:0] a);
      logic [11:0] d;
      d = a[11:0] - `ADDR_GAMMA_BASE;
      gam_index = d[6:2];
   endfunction

   // Each field keeps only its documented width
   function automatic logic [6:0] field_mask(input logic [4:0] i);
      if (i < `IDX_FINE) begin
         field_mask = 7'h7F;
      end else if (i < `IDX_OFFSET) begin
         field_mask = 7'h1F;
      end else begin
         field_mask = 7'h3F;
      end
   endfunction

   function automatic logic [7:0] off_lo(input logic [5:0] n);
      if (n < `OFF_KNEE) begin
         off_lo = {1'b0, n, 1'b0};
      end else begin
         off_lo = {n, 2'b00} - `OFF_LO_BIAS;
      end
   endfunction

   function automatic logic [7:0] off_hi(input logic [5:0] n);
      if (n <= `OFF_KNEE) begin
         off_hi = {n, 2'b00};
      end else begin
         off_hi = {1'b0, n, 1'b0} + `OFF_HI_BIAS;
      end
   endfunction

   assign addr_ok = HSEL && HREADY && HTRANS[1];

   assign color8 = mode.idle && !mode.sleep;

   // one command moves one mode bit; unknown codes do nothing
   function automatic op_mode_t apply_cmd(input op_mode_t   m,
                                          input logic [2:0] code);
      apply_cmd = m;
      case (mode_cmd_t'(code))
         CMD_SLEEP_IN:   apply_cmd.sleep   = 1'b1;
         CMD_SLEEP_OUT:  apply_cmd.sleep   = 1'b0;
         CMD_PARTIAL_ON: apply_cmd.partial = 1'b1;
         CMD_NORMAL_ON:  apply_cmd.partial = 1'b0;
         CMD_IDLE_OFF:   apply_cmd.idle    = 1'b0;
         CMD_IDLE_ON:    apply_cmd.idle    = 1'b1;
         default:        apply_cmd         = m;
      endcase
   endfunction

   // Exact word hit on a control register
   function automatic logic is_reg(input logic [31:0] a,
                                   input logic [11:0] off);
      is_reg = (a == {20'h0_0000, off});
   endfunction

   // Status word: partial, idle and sleep in the three low bits
   function automatic logic [31:0] status_word(input op_mode_t m);
      status_word = {29'h0000_0000, m};
   endfunction

   // field of set member k for the polarity now driven
   function automatic logic [4:0] pol_index(input logic [4:0] first,
                                            input int         k,
                                            input logic       neg);
      pol_index = first + 5'(2 * k) + {4'h0, neg};
   endfunction

   // Panel not driven while asleep, so the stream is blanked
   function automatic logic [5:0] spread_msb(input logic [5:0] v,
                                             input logic       asleep,
                                             input logic       eight);
      if (asleep) begin
         spread_msb = 6'h00;
      end else if (eight) begin
         spread_msb = {6{v[5]}};
      end else begin
         spread_msb = v;
      end
   endfunction

   // Address phase captured for the write data phase that follows
   always_comb begin
      next_wr_pend = addr_ok && HWRITE;
      next_wr_addr = HADDR[11:0];
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
      end
   end

   // Command write commits in its data phase
   always_comb begin
      next_mode = mode;
      if (wr_pend && (wr_addr == `ADDR_CMD)) begin
         next_mode = apply_cmd(mode, HWDATA[2:0]);
      end
   end

   // no power-off state; reset and the sleep-in command return to sleep in
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         mode <= '{partial: `RST_PARTIAL, idle: `RST_IDLE,
                   sleep: `RST_SLEEP};
      end else begin
         mode <= next_mode;
      end
   end

   // Gamma field store; bits beyond each field width read zero
   always_comb begin
      next_gam = gam;
      if (wr_pend && is_gamma({20'h0_0000, wr_addr})) begin
         next_gam[gam_index({20'h0_0000, wr_addr})] =
            HWDATA[6:0] & field_mask(gam_index({20'h0_0000, wr_addr}));
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         for (int i = 0; i < `GAMMA_FIELDS; i++) begin
            gam[i] <= `RST_GAMMA;
         end
      end else begin
         gam <= next_gam;
      end
   end

   // Reads see the value after any write that lands this edge
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (addr_ok && !HWRITE) begin
         if (is_reg(HADDR, `ADDR_CMD)) begin
            next_rdata = 32'h0000_0000;
         end else if (is_reg(HADDR, `ADDR_STATUS)) begin
            next_rdata = status_word(next_mode);
         end else if (is_gamma(HADDR)) begin
            next_rdata = {25'h000_0000, next_gam[gam_index(HADDR)]};
         end
      end
   end

   // Zero-wait slave: HREADYOUT never drops, so no stall path exists
   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         HRDATA    <= 32'h0000_0000;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
         HRDATA    <= next_rdata;
      end
   end

   logic [1:0][7:0] center_dec;
   logic [5:0][7:0] offset_dec;
   logic [6:0][4:0] fine_dec;
   logic [31:0]     gray_on;
   logic [31:0]     ref_on;
   logic [2:0][5:0] comp_in;
   logic [2:0][5:0] comp_out;
   localparam logic [31:0] REF_MASK   = `GRAY_REF;
   localparam logic [31:0] EIGHT_MASK = `GRAY_8COL;

   assign comp_in = PIXEL_IN;

   generate
      for (genvar k = 0; k < 2; k++) begin : g_center
         assign center_dec[k] =
            {gam[pol_index(`IDX_CENTER, k, POLARITY_NEG)], 1'b0};
      end

      for (genvar k = 0; k < 6; k++) begin : g_offset
         logic [5:0] n;
         assign n = gam[pol_index(`IDX_OFFSET, k, POLARITY_NEG)][5:0];
         if (k < 3) begin : g_low
            assign offset_dec[k] = off_lo(n);
         end else begin : g_high
            assign offset_dec[k] = off_hi(n);
         end
      end

      for (genvar k = 0; k < 7; k++) begin : g_fine
         logic [4:0] n;
         assign n = gam[pol_index(`IDX_FINE, k, POLARITY_NEG)][4:0];
         // fine selectors, off in eight colours
         assign fine_dec[k] = color8 ? 5'h00 : n;
      end

      for (genvar g = 0; g < 32; g++) begin : g_gray
         localparam logic END_LEVEL = EIGHT_MASK[g];
         localparam logic REF_LEVEL = REF_MASK[g];
         // Middle levels lose their supply to save power
         assign gray_on[g] = !mode.sleep && (!color8 || END_LEVEL);
         assign ref_on[g]  = gray_on[g] && REF_LEVEL;
      end

      // eight colours keep only each MSB
      for (genvar c = 0; c < 3; c++) begin : g_comp
         assign comp_out[c] = spread_msb(comp_in[c], mode.sleep, color8);
      end
   endgenerate

   // taps follow the polarity one clock later
   always_comb begin
      next_tap            = '0;
      next_tap.center_res = center_dec;
      next_tap.offset_res = offset_dec;
      next_tap.fine_sel   = fine_dec;
      next_tap.fine_en    = !color8;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         GAMMA_TAP <= '0;
      end else begin
         GAMMA_TAP <= next_tap;
      end
   end

   // Power and area controls
   always_comb begin
      next_pwr              = '0;
      next_pwr.boost_en     = !mode.sleep;
      next_pwr.osc_en       = !mode.sleep;
      next_pwr.panel_en     = !mode.sleep;
      next_pwr.partial_area = mode.partial && !mode.sleep;
      next_pwr.color_8      = color8;
      next_pwr.gray_en      = gray_on;
      next_pwr.ref_en       = ref_on;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         POWER_CTL <= '0;
      end else begin
         POWER_CTL <= next_pwr;
      end
   end

   // Pixel stream, one clock behind its input
   always_comb begin
      next_pix = pixel_t'(comp_out);
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
         PIXEL_OUT <= '0;
      end else begin
         PIXEL_OUT <= next_pix;
      end
   end

endmodule

// [gpm_defs.svh]
// Offsets, reset values and decode constants for the mode and gamma block.
// Assumes inclusion by bare name from the design files.
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH

// Register byte offsets inside the 4 KiB slave window
`define ADDR_CMD        12'h000
`define ADDR_STATUS     12'h004
`define ADDR_GAMMA_BASE 12'h100
`define ADDR_GAMMA_LAST 12'h174
`define ADDR_DEC_W      12

// Gamma field table: pos/neg pairs, centre then fine then offset
`define GAMMA_FIELDS    30
`define IDX_CENTER      5'h00
`define IDX_FINE        5'h04
`define IDX_OFFSET      5'h12
`define CENTER_W        7
`define FINE_W          5
`define OFFSET_W        6

// Reset state: normal display, idle off, sleep in
`define RST_PARTIAL     1'b0
`define RST_IDLE        1'b0
`define RST_SLEEP       1'b1
`define RST_GAMMA       7'h00

// Resistor decode: knee at 32, biases in units of R
`define OFF_KNEE        6'h20
`define OFF_LO_BIAS     8'h3E
`define OFF_HI_BIAS     8'h40

// Grayscale supply and reference masks (bit n is grayscale n)
`define GRAY_ALL        32'hFFFF_FFFF
`define GRAY_8COL       32'h8000_0001
`define GRAY_REF        32'hFC20_843F

`endif

// [gpm_pkg.sv]
// Types shared by the mode and gamma control block and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package gpm_pkg;

   typedef enum logic [2:0] {
      CMD_NOP        = 3'h0,
      CMD_SLEEP_IN   = 3'h1,
      CMD_SLEEP_OUT  = 3'h2,
      CMD_PARTIAL_ON = 3'h3,
      CMD_NORMAL_ON  = 3'h4,
      CMD_IDLE_OFF   = 3'h5,
      CMD_IDLE_ON    = 3'h6
   } mode_cmd_t;

   typedef struct packed {
      logic partial;
      logic idle;
      logic sleep;
   } op_mode_t;

   typedef struct packed {
      logic [1:0][7:0] center_res;
      logic [5:0][7:0] offset_res;
      logic [6:0][4:0] fine_sel;
      logic            fine_en;
   } gamma_tap_t;

   typedef struct packed {
      logic        boost_en;
      logic        osc_en;
      logic        panel_en;
      logic        partial_area;
      logic        color_8;
      logic [31:0] gray_en;
      logic [31:0] ref_en;
   } power_ctl_t;

   typedef struct packed {
      logic [5:0] r;
      logic [5:0] g;
      logic [5:0] b;
   } pixel_t;

endpackage

// [gpm_checker_properties.sv]
// Checker for the mode and gamma block, bound to its top module.
// Assumes outputs follow their cause one clock later.
`timescale 1ns/1ns
module gpm_checker (
   // Clock and reset
   input wire logic                REF_CLK,
   input wire logic                RST_B,
   // Watched outputs and their pixel cause
   input wire gpm_pkg::pixel_t     PIXEL_IN,
   input wire gpm_pkg::pixel_t     PIXEL_OUT,
   input wire gpm_pkg::gamma_tap_t GAMMA_TAP,
   input wire gpm_pkg::power_ctl_t POWER_CTL
);
   import gpm_pkg::*;
   power_ctl_t p;
   assign p = POWER_CTL;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // Top bit of each component spread over all six bits
   function automatic pixel_t msb(pixel_t x);
      return {{6{x.r[5]}}, {6{x.g[5]}}, {6{x.b[5]}}};
   endfunction
   sleep_dark_a: assert property (
      !p.osc_en |-> p.gray_en == 0 && p.ref_en == 0 && PIXEL_OUT == 0)
      else $error("panel driven while asleep");
   drive_group_a: assert property (
      p.boost_en == p.osc_en && p.panel_en == p.osc_en)
      else $error("power enables disagree");
   sleep_wins_a: assert property (
      !p.osc_en |-> !p.color_8 && !p.partial_area)
      else $error("display mode shown while asleep");
   eight_gray_a: assert property (
      p.color_8 |-> p.gray_en == 32'h8000_0001)
      else $error("middle grays powered in eight colours");
   fine_off_a: assert property (
      p.color_8 |-> !GAMMA_TAP.fine_en && GAMMA_TAP.fine_sel == 0)
      else $error("fine selectors live in eight colours");
   msb_pixel_a: assert property (
      p.color_8 |-> PIXEL_OUT == msb($past(PIXEL_IN)))
      else $error("eight colour pixel wrong");
   full_pixel_a: assert property (
      p.osc_en && !p.color_8 |-> PIXEL_OUT == $past(PIXEL_IN)
         && p.gray_en == 32'hFFFF_FFFF)
      else $error("full colour path wrong");
   ref_taps_a: assert property (
      p.osc_en && !p.color_8 |-> p.ref_en == 32'hFC20_843F)
      else $error("reference levels wrong");
endmodule

bind gamma_power_mode_control gpm_checker i_chk (
   .REF_CLK  (REF_CLK),
   .RST_B    (RST_B),
   .PIXEL_IN (PIXEL_IN),
   .PIXEL_OUT(PIXEL_OUT),
   .GAMMA_TAP(GAMMA_TAP),
   .POWER_CTL(POWER_CTL)
);

// [host_model.sv]
// Host master model issuing single word transfers to the block.
// Assumes one slave whose ready output is the bus ready.
`timescale 1ns/1ns
module host_model (
   // Clock and slave answer
   input  wire logic        REF_CLK,
   input  wire logic        HREADYOUT,
   input  wire logic [31:0] HRDATA,
   // Master request
   output      logic        HSEL = 1'h0,
   output      logic [31:0] HADDR = 32'h0,
   output      logic [1:0]  HTRANS = 2'h0,
   output      logic        HWRITE = 1'h0,
   output      logic [2:0]  HSIZE = 3'h2,
   output      logic [31:0] HWDATA = 32'h0
);
   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q, output logic hung);
      int n = 0;
      @(posedge REF_CLK);
      HSEL   <= 1'h1;
      HTRANS <= 2'h2;
      HADDR  <= a;
      HWRITE <= w;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'h1 && ++n < 50);
      HSEL   <= 1'h0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      do @(posedge REF_CLK); while (HREADYOUT !== 1'h1 && ++n < 50);
      q    = HRDATA;
      hung = n >= 50;
   endtask
endmodule

// [gamma_power_mode_control_tb_top.sv]
// Self-checking bench for the mode and gamma control block.
// Assumes the host model speaks the bus and outputs lag one cycle.
`timescale 1ns/1ns
module gamma_power_mode_control_tb_top;
   import gpm_pkg::*;
   logic        ref_clk = 1'h0;
   logic        rst_b = 1'h0;
   logic        pol_neg = 1'h0;
   pixel_t      pix_in = 18'h2_A561;
   logic        hsel, hwrite, hready, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q;
   gamma_tap_t  tap;
   power_ctl_t  pwr;
   pixel_t      pix_out;
   int          n_errors = 0;
   int          num_checks = 0;
   logic [31:0] cv [4] = '{32'hFFFF_FFFF, 32'h1, 32'h3F, 32'h0};
   int          ov [6] = '{31, 32, 63, 32, 33, 63};

   always #5 ref_clk = ~ref_clk;

   host_model i_host (.REF_CLK(ref_clk), .HREADYOUT(hready),
      .HRDATA(hrdata), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
   gamma_power_mode_control i_dut (.REF_CLK(ref_clk), .RST_B(rst_b),
      .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
      .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
      .POLARITY_NEG(pol_neg), .PIXEL_IN(pix_in), .GAMMA_TAP(tap),
      .POWER_CTL(pwr), .PIXEL_OUT(pix_out));

   task automatic finish_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(string what, logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(logic w, logic [31:0] a, d = 32'h0);
      logic hung;
      i_host.xfer(w, a, d, q, hung);
      if (hung) begin
         n_errors++;
         finish_test();
      end
   endtask
   // Write lands at the third edge of the bus task, outputs one edge later
   task automatic cmd(logic [2:0] c);
      bus(1'h1, 32'h0, {29'h0, c});
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   function automatic logic [31:0] off_res(int k, int n);
      if (k < 3)
         return n < 32 ? 2 * n : 4 * n - 62;
      return n <= 32 ? 4 * n : 2 * n + 64;
   endfunction

   task automatic t_reset();
      bus(1'h0, 32'h4);
      chk("status", q, 32'h1);
      chk("resp", hresp, 32'h0);
      chk("drive", {pwr.boost_en, pwr.osc_en, pwr.panel_en}, 32'h0);
   endtask
   task automatic t_modes();
      cmd(CMD_SLEEP_OUT);
      for (int m = 0; m < 4; m++) begin
         cmd(m[1] ? CMD_PARTIAL_ON : CMD_NORMAL_ON);
         cmd(m[0] ? CMD_IDLE_ON : CMD_IDLE_OFF);
         cmd(3'h7);
         bus(1'h0, 32'h4);
         chk("status", q, {29'h0, m[1:0], 1'h0});
         chk("area", pwr.partial_area, m[1]);
         chk("colour", pwr.color_8, m[0]);
         chk("pixel", pix_out, m[0] ? 18'h3_F03F : pix_in);
         chk("fine", tap.fine_en, !m[0]);
      end
      cmd(CMD_SLEEP_IN);
      bus(1'h0, 32'h4);
      chk("status", q, 32'h7);
      chk("boost", pwr.boost_en, 32'h0);
   endtask
   task automatic t_gamma();
      for (int i = 0; i < 4; i++)
         bus(1'h1, 32'h100 + 4 * i, cv[i]);
      for (int k = 0; k < 7; k++) begin
         bus(1'h1, 32'h110 + 8 * k, 16 + k);
         bus(1'h1, 32'h114 + 8 * k, 2 * k + 1);
      end
      for (int k = 0; k < 6; k++) begin
         bus(1'h1, 32'h148 + 8 * k, ov[k]);
         bus(1'h1, 32'h14C + 8 * k, ov[k] - 1);
      end
      bus(1'h0, 32'h100);
      chk("readback", q, 32'h7F);
      bus(1'h0, 32'h200);
      chk("unmapped", q, 32'h0);
      for (int p = 0; p < 2; p++) begin
         @(posedge ref_clk);
         pol_neg <= p[0];
         repeat (2) @(posedge ref_clk);
         #1;
         for (int k = 0; k < 2; k++)
            chk("centre", tap.center_res[k], 2 * (cv[2*k+p] & 127));
         for (int k = 0; k < 7; k++)
            chk("fine", tap.fine_sel[k], p ? 2 * k + 1 : 16 + k);
         for (int k = 0; k < 6; k++)
            chk("offset", tap.offset_res[k], off_res(k, ov[k] - p));
      end
      cmd(CMD_SLEEP_OUT);
      chk("fine off", tap.fine_sel[6], 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'h1;
      t_reset();
      t_modes();
      t_gamma();
      finish_test();
   end
endmodule
